// ### common/tdm_pkg.sv
// package for the transmit data link source selector
// assumes a single hclk domain and an AHB-Lite register slave
package tdm_pkg;
	// register map: printed offset 0x0a is not a multiple of four, so it is an index
	localparam logic [7:0] TDM_SEL_INDEX = 8'h0a;
	localparam logic [7:0] TDM_CTRL_INDEX = 8'h0b;
	localparam logic [11:0] TDM_SEL_ADDR = {2'b00, TDM_SEL_INDEX, 2'b00};
	localparam logic [11:0] TDM_CTRL_ADDR = {2'b00, TDM_CTRL_INDEX, 2'b00};
	localparam logic [11:0] TDM_STAT_ADDR = 12'h0030;
	localparam logic [7:0] TDM_SEL_RESET = 8'h00;
	localparam logic [7:0] TDM_CTRL_RESET = 8'h00;
	// field positions in the select register
	localparam int TDM_FDL_SRC_LSB = 0;
	localparam int TDM_DE_SRC_LSB = 2;
	localparam int TDM_BW_LSB = 4;
	// field positions in the control register
	localparam int TDM_CHSEL_LSB = 0;
	localparam int TDM_ESF_BIT = 2;

	typedef enum logic [1:0] {
		TDM_FDL_CTRL = 2'b00,
		TDM_FDL_SERIAL = 2'b01,
		TDM_FDL_OVERHEAD = 2'b10,
		TDM_FDL_ONES = 2'b11
	} tdm_fdl_src_t;

	typedef enum logic [1:0] {
		TDM_DE_SERIAL = 2'b00,
		TDM_DE_UNDEF = 2'b01,
		TDM_DE_CTRL = 2'b10,
		TDM_DE_FRAC = 2'b11
	} tdm_de_src_t;

	typedef enum logic [1:0] {
		TDM_BW_4K = 2'b00,
		TDM_BW_ODD = 2'b01,
		TDM_BW_EVEN = 2'b10,
		TDM_BW_ALT = 2'b11
	} tdm_bw_t;

	localparam logic [1:0] TDM_CHSEL_DE = 2'b10;

	// data link source candidates for one bit slot
	typedef struct packed {
		logic ctrl;
		logic serial;
		logic overhead;
		logic frac;
	} tdm_src_t;

	// frame position of the current bit slot
	typedef struct packed {
		logic fdl_slot;
		logic frame_odd_fdl;
		logic de_slot;
		logic esf;
	} tdm_pos_t;
endpackage

// ### verilog/tdm_mux.sv
// transmit data link and D/E timeslot source selector with its AHB-Lite register slave
// assumes frame position strobes and source bits arrive on hclk from framer logic
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps

// Function
// - ESF bandwidth code 00 uses every FACILITY_DATA_LINK position as a 4 kHz link.
// - code 01 uses only odd FACILITY_DATA_LINK positions, frames 1, 5, 9.
// - code 10 uses only even FACILITY_DATA_LINK positions, frames 3, 7, 11.
// - D/E source field acts only when channel select equals 10.
// - D/E code 00 takes data from the serial input.
// - D/E code 10 takes data from the link controllers.
// - D/E code 11 takes data from the fractional input.
// - FACILITY_DATA_LINK code 00 takes bits from controller or loop buffer.
// - FACILITY_DATA_LINK code 01 takes bits from the serial input.
// - FACILITY_DATA_LINK code 10 takes bits from the overhead input.
// - FACILITY_DATA_LINK code 11 forces every link bit to one.
module tdm_mux
	import tdm_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// frame position and source bits
	input wire tdm_pos_t pos,
	input wire tdm_src_t fdl_in,
	input wire tdm_src_t de_in,
	input wire logic tx_payload_in,
	// selected transmit bit and its source take flags
	output logic tx_data_out,
	output logic fdl_take,
	output logic de_take
);
	logic [7:0] sel_q;
	logic [7:0] ctrl_q;
	logic wr_pend_q;
	logic [11:0] addr_q;
	logic [31:0] rdata_q;
	logic [7:0] stat_q;
	logic fdl_bit_d;
	logic de_bit_d;
	logic out_d;
	logic fdl_use;
	logic de_active;
	logic accept;
	tdm_fdl_src_t fdl_src;
	tdm_de_src_t de_src;
	tdm_bw_t bw;

	assign fdl_src = tdm_fdl_src_t'(sel_q[TDM_FDL_SRC_LSB +: 2]);
	assign de_src = tdm_de_src_t'(sel_q[TDM_DE_SRC_LSB +: 2]);
	assign bw = tdm_bw_t'(sel_q[TDM_BW_LSB +: 2]);
	assign accept = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 12'h000;
		end else if (hready) begin
			wr_pend_q <= accept && hwrite;
			addr_q <= haddr;
		end
	end

	// register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q <= TDM_SEL_RESET;
			ctrl_q <= TDM_CTRL_RESET;
		end else if (wr_pend_q) begin
			if (addr_q == TDM_SEL_ADDR)
				sel_q <= hwdata[7:0];
			if (addr_q == TDM_CTRL_ADDR)
				ctrl_q <= {5'h00, hwdata[2:0]};
		end
	end

	// read data, zero for unmapped addresses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (accept && !hwrite) begin
			case (haddr)
				TDM_SEL_ADDR: rdata_q <= {24'h00_0000, sel_q};
				TDM_CTRL_ADDR: rdata_q <= {24'h00_0000, ctrl_q};
				TDM_STAT_ADDR: rdata_q <= {24'h00_0000, stat_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// bandwidth thinning of FACILITY_DATA_LINK positions
	always_comb begin
		case (bw)
			TDM_BW_4K: fdl_use = pos.fdl_slot;
			TDM_BW_ODD: fdl_use = pos.fdl_slot && pos.frame_odd_fdl;
			TDM_BW_EVEN: fdl_use = pos.fdl_slot && !pos.frame_odd_fdl;
			TDM_BW_ALT: fdl_use = pos.fdl_slot;
			default: fdl_use = pos.fdl_slot;
		endcase
		if (!pos.esf)
			fdl_use = pos.fdl_slot;
	end

	// fdl source choice
	always_comb begin
		case (fdl_src)
			TDM_FDL_CTRL: fdl_bit_d = fdl_in.ctrl;
			TDM_FDL_SERIAL: fdl_bit_d = fdl_in.serial;
			TDM_FDL_OVERHEAD: fdl_bit_d = fdl_in.overhead;
			TDM_FDL_ONES: fdl_bit_d = 1'b1;
			default: fdl_bit_d = 1'b1;
		endcase
	end

	// D/E source choice; the payload stream bit passes when the field is not in force
	assign de_active = pos.de_slot && (ctrl_q[TDM_CHSEL_LSB +: 2] == TDM_CHSEL_DE);
	always_comb begin
		case (de_src)
			TDM_DE_SERIAL: de_bit_d = de_in.serial;
			TDM_DE_UNDEF: de_bit_d = de_in.serial;
			TDM_DE_CTRL: de_bit_d = de_in.ctrl;
			TDM_DE_FRAC: de_bit_d = de_in.frac;
			default: de_bit_d = de_in.serial;
		endcase
	end

	// final bit; unused FACILITY_DATA_LINK positions carry the payload stream bit
	always_comb begin
		out_d = tx_payload_in;
		if (fdl_use)
			out_d = fdl_bit_d;
		else if (de_active)
			out_d = de_bit_d;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_data_out <= 1'b0;
			fdl_take <= 1'b0;
			de_take <= 1'b0;
		end else begin
			tx_data_out <= out_d;
			fdl_take <= fdl_use;
			de_take <= de_active && !fdl_use;
		end
	end

	// status: live selection state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			stat_q <= 8'h00;
		else
			stat_q <= {4'h0, pos.esf, de_active, fdl_use, out_d};
	end
endmodule // tdm_mux

// ### dv/tdm_mux_sva.sv
// checker on the selector ports
// assumes hsel high and zero-wait bus
`timescale 1ns/10ps
module tdm_chk
	import tdm_pkg::*;
(
	// clock, reset, bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	// bit path
	input wire tdm_pos_t pos,
	input wire tdm_src_t fdl_in,
	input wire logic tx_data_out,
	input wire logic fdl_take
);
	logic [7:0] s_q;
	// mirror of the select register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s_q <= TDM_SEL_RESET;
		else if ($past(htrans[1] && hwrite && haddr == TDM_SEL_ADDR))
			s_q <= hwdata[7:0];
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_no_slot: assert property (!$past(pos.fdl_slot) |-> !fdl_take)
		else $error("no slot");
	chk_full_use: assert property ($past(pos.fdl_slot && s_q[5] == s_q[4]) |-> fdl_take)
		else $error("unused");
	chk_odd_only: assert property ($past(pos.esf && s_q[5:4] == 2'h1 && !pos.frame_odd_fdl) |-> !fdl_take)
		else $error("even used");
	chk_even_only: assert property ($past(pos.esf && s_q[5:4] == 2'h2 && pos.frame_odd_fdl) |-> !fdl_take)
		else $error("odd used");
	chk_ctrl_src: assert property (fdl_take && $past(s_q[1:0]) == 2'h0 |-> tx_data_out == $past(fdl_in.ctrl))
		else $error("ctrl");
	chk_ser_src: assert property (fdl_take && $past(s_q[1:0]) == 2'h1 |-> tx_data_out == $past(fdl_in.serial))
		else $error("serial");
	chk_oh_src: assert property (fdl_take && $past(s_q[1:0]) == 2'h2 |-> tx_data_out == $past(fdl_in.overhead))
		else $error("overhead");
	chk_ones_src: assert property (fdl_take && $past(s_q[1:0]) == 2'h3 |-> tx_data_out)
		else $error("ones");
endmodule // tdm_chk
bind tdm_mux tdm_chk u_tdm_chk (.hclk, .hresetn, .haddr, .htrans, .hwrite, .hwdata, .pos, .fdl_in,
	.tx_data_out, .fdl_take);

// ### dv/tdm_src_model.sv
// source pins model feeding the selector
// shifts a new pattern on each hclk
`timescale 1ns/10ps
module tdm_src_model
	import tdm_pkg::*;
(
	// clock and source bits
	input wire logic hclk,
	output tdm_src_t fdl_in,
	output tdm_src_t de_in,
	output logic tx_payload_in
);
	logic [8:0] n_q = 9'h0a5;
	always_ff @(posedge hclk)
		n_q <= {n_q[7:0], n_q[8] ^ n_q[4]};
	assign {fdl_in, de_in, tx_payload_in} = n_q;
endmodule // tdm_src_model

// ### dv/tb_top.sv
// bench for the link source selector
// ahb-lite master tasks, source model beside
`timescale 1ns/10ps
module tb_top;
	import tdm_pkg::*;
	logic hclk = '0, hresetn = '0, hwrite = '0, hreadyout, hresp, tx_payload_in, tx_data_out, fdl_take, de_take;
	logic [1:0] htrans = '0;
	logic [11:0] haddr = '0;
	logic [31:0] hwdata = '0, hrdata;
	logic [7:0] sv, cv;
	tdm_pos_t pos = '0;
	tdm_src_t fdl_in, de_in;
	int bad_count = 0, checks = 0, cyc = 0;
	always #25 hclk = ~hclk;
	tdm_src_model u_tdm_src_model (.hclk, .fdl_in, .de_in, .tx_payload_in);
	tdm_mux u_tdm_mux (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .pos, .fdl_in, .de_in, .tx_payload_in,
		.tx_data_out, .fdl_take, .de_take);
	task automatic complete_run;
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge hclk)
		if (++cyc > 2000) begin
			bad_count++;
			complete_run;
		end
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
	endtask
	task automatic set(input logic [7:0] s, input logic [7:0] c);
		sv = s;
		cv = c;
		bus(1'h1, TDM_SEL_ADDR, {24'h00_0000, s});
		bus(1'h1, TDM_CTRL_ADDR, {24'h00_0000, c});
	endtask
	// one bit slot: expectation from the inputs the design samples
	task automatic slot(input tdm_pos_t p);
		logic f, d, e;
		pos <= p;
		@(posedge hclk);
		f = p.fdl_slot && (!p.esf || sv[5] == sv[4] || sv[4] == p.frame_odd_fdl);
		d = p.de_slot && cv[1:0] == TDM_CHSEL_DE && !f;
		e = f ? sv[1:0] == 2'h3 || fdl_in[~sv[1:0]] : d ? de_in[sv[3] ? {2{~sv[2]}} : 2'h2] : tx_payload_in;
		@(posedge hclk);
		cmp("out", {29'h0, e, f, d}, {29'h0, tx_data_out, fdl_take, de_take});
	endtask
	task automatic reg_cases;
		bus(1'h0, TDM_SEL_ADDR, '0);
		cmp("sel reset", {24'h00_0000, TDM_SEL_RESET}, hrdata);
		set(8'hff, 8'h02);
		bus(1'h0, TDM_SEL_ADDR, '0);
		cmp("sel rw", 32'h0000_00ff, hrdata);
		bus(1'h0, TDM_CTRL_ADDR, '0);
		cmp("ctrl rw", 32'h0000_0002, hrdata);
		cmp("resp", 32'h0000_0000, {31'h0, hresp});
		bus(1'h0, 12'h3f0, '0);
		cmp("unmapped", 32'h0000_0000, hrdata);
	endtask
	task automatic fdl_cases;
		for (int i = 0; i < 16; i++) begin
			set({2'h0, i[3:2], 2'h0, i[1:0]}, 8'h00);
			for (int k = 0; k < 4; k++)
				slot({1'h1, k[0], 1'h0, k[1]});
		end
	endtask
	task automatic de_cases;
		for (int i = 0; i < 8; i++) begin
			set({4'h0, i[1:0], 2'h3}, {6'h00, i[2], ~i[2]});
			slot(4'h2);
			slot(4'h0);
		end
	endtask
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		reg_cases;
		fdl_cases;
		de_cases;
		complete_run;
	end
endmodule // tb_top
